//--- pkg/sdl_map.svh
`ifndef SDL_MAP_SVH
`define SDL_MAP_SVH

// Word and field layout of the held code
`define SDL_WORD_BITS     16
`define SDL_SEG_BITS      4
`define SDL_SEG_COUNT     15
`define SDL_LADDER_BITS   12
`define SDL_SEG_MSB       15
`define SDL_SEG_LSB       12
`define SDL_LADDER_MSB    11
`define SDL_LADDER_LSB    0

// Power-up code: zero volts unipolar, negative full scale bipolar
`define SDL_CODE_RESET    16'h0000

// Bit counter in the link domain
`define SDL_CNT_BITS      5
`define SDL_CNT_LAST_BIT  5'h0f
`define SDL_CNT_EXTRA_BIT 5'h10
`define SDL_CNT_SATURATE  5'h11

// Timing: system clock and select release to strobe low, in ns
`define SDL_SYS_PERIOD_NS 10
`define SDL_T_CS_TO_LD_NS 60
`define SDL_CS_TO_LD_CYC  ((`SDL_T_CS_TO_LD_NS + `SDL_SYS_PERIOD_NS - 1) / `SDL_SYS_PERIOD_NS)

`endif

//--- pkg/sdl_pkg.sv
`include "sdl_map.svh"

package sdl_pkg;

  // What the link domain hands to the system domain
  typedef struct packed {
    logic [`SDL_WORD_BITS-1:0] word;
    logic                      word_toggle;
    logic                      extra_toggle;
  } sdl_link_word_type;

  // Switch controls of the two converter sections
  typedef struct packed {
    logic [`SDL_SEG_COUNT-1:0]   segment;
    logic [`SDL_LADDER_BITS-1:0] ladder;
  } sdl_switch_type;

  // Phase of a select frame as seen in the system domain
  typedef enum logic [1:0] {
    SDL_IDLE,
    SDL_FRAME,
    SDL_RELEASE
  } sdl_frame_state_type;

endpackage : sdl_pkg

//--- hw/sdl_link_shift.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"

module sdl_link_shift (
  // Link clock and reset
  input  wire logic                   clk_link_in,
  input  wire logic                   reset_in,
  // Link pins
  input  wire logic                   select_n_in,
  input  wire logic                   data_in,
  // Toward the system domain
  output sdl_pkg::sdl_link_word_type  link_out
);

  logic [`SDL_WORD_BITS-1:0] shift_reg;
  logic [`SDL_CNT_BITS-1:0]  count_reg;
  logic                      word_toggle_reg;
  logic                      extra_toggle_reg;
  logic                      frame_clear;

  // Released select clears the count without any shift clock edge
  assign frame_clear = reset_in | select_n_in;

  // MSB first: older bits move up, newest enters bit 0
  always_ff @(posedge clk_link_in or posedge reset_in) begin
    if (reset_in) begin
      shift_reg <= `SDL_CODE_RESET;
    end else if (!select_n_in) begin
      shift_reg <= {shift_reg[`SDL_WORD_BITS-2:0], data_in};
    end
  end

  always_ff @(posedge clk_link_in or posedge frame_clear) begin
    if (frame_clear) begin
      count_reg <= '0;
    end else if (count_reg != `SDL_CNT_SATURATE) begin
      count_reg <= count_reg + `SDL_CNT_BITS'(1);
    end
  end

  // Toggles, not pulses: the link clock may stop right after the edge
  always_ff @(posedge clk_link_in or posedge reset_in) begin
    if (reset_in) begin
      word_toggle_reg <= 1'b0;
    end else if (!select_n_in && count_reg == `SDL_CNT_LAST_BIT) begin
      word_toggle_reg <= ~word_toggle_reg;
    end
  end

  always_ff @(posedge clk_link_in or posedge reset_in) begin
    if (reset_in) begin
      extra_toggle_reg <= 1'b0;
    end else if (!select_n_in && count_reg == `SDL_CNT_EXTRA_BIT) begin
      extra_toggle_reg <= ~extra_toggle_reg;
    end
  end

  assign link_out.word         = shift_reg;
  assign link_out.word_toggle  = word_toggle_reg;
  assign link_out.extra_toggle = extra_toggle_reg;

endmodule : sdl_link_shift

`default_nettype wire

//--- hw/sdl_segment_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"

module sdl_segment_decode (
  // Clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      reset_in,
  // Held code
  input  wire logic [`SDL_WORD_BITS-1:0] code_in,
  // Switch controls, registered
  output sdl_pkg::sdl_switch_type        switch_out
);

  sdl_pkg::sdl_switch_type switch_reg;
  sdl_pkg::sdl_switch_type switch_next;

  // Segment i goes to the reference when i is below the nibble value
  function automatic logic [`SDL_SEG_COUNT-1:0] thermometer(input logic [`SDL_SEG_BITS-1:0] nibble);
    logic [`SDL_SEG_COUNT-1:0] result;
    result = '0;
    for (int i = 0; i < `SDL_SEG_COUNT; i++) begin
      result[i] = (i < int'(nibble));
    end
    return result;
  endfunction : thermometer

  always_comb begin
    switch_next.segment = thermometer(code_in[`SDL_SEG_MSB:`SDL_SEG_LSB]);
    switch_next.ladder  = code_in[`SDL_LADDER_MSB:`SDL_LADDER_LSB];
  end

  // Reset image matches the power-up code
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      switch_reg <= '0;
    end else begin
      switch_reg <= switch_next;
    end
  end

  assign switch_out = switch_reg;

endmodule : sdl_segment_decode

`default_nettype wire

//--- hw/sdl_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"

module sdl_top (
  // System clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        reset_in,
  // Serial link from the host
  input  wire logic                        clk_link_in,
  input  wire logic                        select_n_in,
  input  wire logic                        data_in,
  input  wire logic                        load_strobe_n_in,
  // Converter switch controls
  output logic [`SDL_SEG_COUNT-1:0]        segment_switch_out,
  output logic [`SDL_LADDER_BITS-1:0]      ladder_switch_out,
  // Held code and frame status
  output logic [`SDL_WORD_BITS-1:0]        code_out,
  output logic                             word_pending_out,
  output logic                             frame_short_out,
  output logic                             frame_long_out
);

  sdl_pkg::sdl_link_word_type  link_word;
  sdl_pkg::sdl_switch_type     switches;
  sdl_pkg::sdl_frame_state_type state_reg;
  sdl_pkg::sdl_frame_state_type state_next;

  logic [3:0]                cs_sync_reg;
  logic [1:0]                strobe_sync_reg;
  logic [2:0]                word_tog_reg;
  logic [2:0]                extra_tog_reg;
  logic                      got_word_reg;
  logic                      got_extra_reg;
  logic [`SDL_WORD_BITS-1:0] input_copy_reg;
  logic [`SDL_WORD_BITS-1:0] code_reg;
  logic                      pending_reg;
  logic                      short_reg;
  logic                      long_reg;
  logic                      cs_fall;
  logic                      cs_rise;
  logic                      cs_idle;
  logic                      strobe_low;
  logic                      word_event;
  logic                      extra_event;
  logic                      frame_end;
  logic                      convert_now;

  // One stage high while the next is still low marks a level change
  function automatic logic step_between(input logic high_stage, input logic low_stage);
    return high_stage & ~low_stage;
  endfunction : step_between

  // Each change of a handed-over toggle is one link event
  function automatic logic toggle_seen(input logic newer, input logic older);
    return newer ^ older;
  endfunction : toggle_seen

  sdl_link_shift u_link (
    .clk_link_in (clk_link_in),
    .reset_in    (reset_in),
    .select_n_in (select_n_in),
    .data_in     (data_in),
    .link_out    (link_word)
  );

  // Select runs one stage longer than the toggles so the last
  // word event is always seen before the release
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cs_sync_reg <= 4'hf;
    end else begin
      cs_sync_reg <= {cs_sync_reg[2:0], select_n_in};
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      strobe_sync_reg <= 2'h3;
    end else begin
      strobe_sync_reg <= {strobe_sync_reg[0], load_strobe_n_in};
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      word_tog_reg <= 3'h0;
    end else begin
      word_tog_reg <= {word_tog_reg[1:0], link_word.word_toggle};
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      extra_tog_reg <= 3'h0;
    end else begin
      extra_tog_reg <= {extra_tog_reg[1:0], link_word.extra_toggle};
    end
  end

  assign cs_fall     = step_between(cs_sync_reg[3], cs_sync_reg[2]);
  assign cs_rise     = step_between(cs_sync_reg[2], cs_sync_reg[3]);
  assign cs_idle     = cs_sync_reg[2] & cs_sync_reg[3];
  assign strobe_low  = ~strobe_sync_reg[1];
  assign word_event  = toggle_seen(word_tog_reg[1], word_tog_reg[2]);
  assign extra_event = toggle_seen(extra_tog_reg[1], extra_tog_reg[2]);
  // A release only counts when a frame was opened first
  assign frame_end   = cs_rise && (state_reg == sdl_pkg::SDL_FRAME);
  assign convert_now = strobe_low && cs_idle && (state_reg != sdl_pkg::SDL_FRAME);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sdl_pkg::SDL_IDLE: begin
        if (cs_fall) begin
          state_next = sdl_pkg::SDL_FRAME;
        end
      end
      sdl_pkg::SDL_FRAME: begin
        if (cs_rise) begin
          state_next = sdl_pkg::SDL_RELEASE;
        end
      end
      sdl_pkg::SDL_RELEASE: begin
        state_next = sdl_pkg::SDL_IDLE;
      end
      default: begin
        state_next = sdl_pkg::SDL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= sdl_pkg::SDL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Frame summary; an event in the clearing cycle still counts
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      got_word_reg <= 1'b0;
    end else begin
      got_word_reg <= word_event | (got_word_reg & ~cs_fall);
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      got_extra_reg <= 1'b0;
    end else begin
      got_extra_reg <= extra_event | (got_extra_reg & ~cs_fall);
    end
  end

  // Word is stable here: the shifter only moves while selected
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      input_copy_reg <= `SDL_CODE_RESET;
    end else if (frame_end && got_word_reg) begin
      input_copy_reg <= link_word.word;
    end
  end

  // Short frames are dropped, long ones keep the last sixteen bits
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      short_reg <= 1'b0;
    end else if (frame_end) begin
      short_reg <= ~got_word_reg;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      long_reg <= 1'b0;
    end else if (frame_end) begin
      long_reg <= got_extra_reg;
    end
  end

  // Mid-frame the shifter is unsafe to read, so the converter holds
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      code_reg <= `SDL_CODE_RESET;
    end else if (convert_now) begin
      code_reg <= input_copy_reg;
    end
  end

  // Preload waits for the strobe; a new word wins over the clear
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pending_reg <= 1'b0;
    end else if (frame_end && got_word_reg) begin
      pending_reg <= 1'b1;
    end else if (convert_now) begin
      pending_reg <= 1'b0;
    end
  end

  sdl_segment_decode u_decode (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .code_in    (code_reg),
    .switch_out (switches)
  );

  assign segment_switch_out = switches.segment;
  assign ladder_switch_out  = switches.ladder;
  assign code_out           = code_reg;
  assign word_pending_out   = pending_reg;
  assign frame_short_out    = short_reg;
  assign frame_long_out     = long_reg;

endmodule : sdl_top

`default_nettype wire

//--- dv/sdl_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"

module sdl_top_monitor (
  // Clock, reset and link pins
  input wire logic                        clk_sys_in,
  input wire logic                        reset_in,
  input wire logic                        clk_link_in,
  input wire logic                        select_n_in,
  input wire logic                        data_in,
  input wire logic                        load_strobe_n_in,
  // Outputs under watch
  input wire logic [`SDL_SEG_COUNT-1:0]   segment_switch_out,
  input wire logic [`SDL_LADDER_BITS-1:0] ladder_switch_out,
  input wire logic [`SDL_WORD_BITS-1:0]   code_out,
  input wire logic                        word_pending_out,
  input wire logic                        frame_short_out,
  input wire logic                        frame_long_out
);
  function automatic logic [14:0] thermo(input logic [3:0] n);
    thermo = 15'h7fff >> (5'h0f - {1'b0, n});
  endfunction : thermo

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // Long enough for a release copy to have landed
  sequence s_idle_load;
    (select_n_in && !load_strobe_n_in) [*7];
  endsequence
  sequence s_in_frame;
    !select_n_in [*8];
  endsequence

  chk_ladder_direct: assert property (ladder_switch_out == $past(code_out[11:0]))
    else $error("ladder differs from held code");
  chk_segment_thermo: assert property (segment_switch_out == thermo($past(code_out[15:12])))
    else $error("segment controls not thermometer of upper nibble");
  chk_frame_hold: assert property (s_in_frame |-> $stable(code_out))
    else $error("code changed during a frame");
  chk_follow_idle: assert property (s_idle_load |-> !word_pending_out)
    else $error("preloaded word not moved with strobe low");
  chk_copy_pending: assert property ($changed(code_out) |-> $past(word_pending_out))
    else $error("code changed without a complete word");
  chk_copy_released: assert property ($changed(code_out) |-> $past(select_n_in, 4) && $past(select_n_in, 5))
    else $error("code changed too soon after select");
  chk_status_excl: assert property (!(frame_short_out && frame_long_out))
    else $error("short and long both set");
  chk_hold_preload: assert property (load_strobe_n_in [*8] |-> $stable(code_out))
    else $error("code changed with strobe high");
  chk_reset_zero: assert property ($fell(reset_in) |-> code_out == `SDL_CODE_RESET && !word_pending_out)
    else $error("code not zero after reset");
endmodule : sdl_top_monitor

bind sdl_top sdl_top_monitor mon (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_link_in(clk_link_in),
  .select_n_in(select_n_in), .data_in(data_in), .load_strobe_n_in(load_strobe_n_in),
  .segment_switch_out(segment_switch_out), .ladder_switch_out(ladder_switch_out), .code_out(code_out),
  .word_pending_out(word_pending_out), .frame_short_out(frame_short_out), .frame_long_out(frame_long_out));

`default_nettype wire

//--- dv/sdl_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sdl_host_model (
  // Link pins toward the device
  output logic clk_link_out,
  output logic select_n_out,
  output logic data_out,
  output logic load_strobe_n_out
);
  initial begin
    clk_link_out = 1'b0;
    select_n_out = 1'b1;
    data_out = 1'b0;
    load_strobe_n_out = 1'b0;
  end

  task automatic set_strobe(input logic level);
    load_strobe_n_out = level;
  endtask : set_strobe

  // Low n bits of bits, msb first; sel low leaves select released
  task automatic send(input logic [31:0] bits, input int n, input logic sel);
    #7.3;
    select_n_out = !sel;
    for (int i = n - 1; i >= 0; i--) begin
      data_out = bits[i];
      #40;
      clk_link_out = 1'b1;
      #40;
      clk_link_out = 1'b0;
    end
    #40;
    select_n_out = 1'b1;
    // Released line must not keep showing the last bit
    data_out = !data_out;
  endtask : send
endmodule : sdl_host_model

`default_nettype wire

//--- dv/sdl_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"

module sdl_top_tb;
  logic        clk_sys_in;
  logic        reset_in;
  logic        clk_link;
  logic        select_n;
  logic        data;
  logic        strobe_n;
  logic [14:0] segment;
  logic [11:0] ladder;
  logic [15:0] code;
  logic        pending;
  logic        short_f;
  logic        long_f;
  logic [31:0] seed;
  logic [15:0] held;
  logic [15:0] word;
  logic [15:0] corners [4] = '{16'h0000, 16'hffff, 16'h8001, 16'h7ffe};
  int          mismatches;
  int          num_checks;

  always #5 clk_sys_in = ~clk_sys_in;

  sdl_top dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_link_in(clk_link), .select_n_in(select_n),
    .data_in(data), .load_strobe_n_in(strobe_n), .segment_switch_out(segment), .ladder_switch_out(ladder),
    .code_out(code), .word_pending_out(pending), .frame_short_out(short_f), .frame_long_out(long_f));
  sdl_host_model host (.clk_link_out(clk_link), .select_n_out(select_n), .data_out(data),
    .load_strobe_n_out(strobe_n));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction : xorshift

  function automatic logic [14:0] thermo_of(input logic [15:0] w);
    thermo_of = 15'h7fff >> (5'h0f - {1'b0, w[15:12]});
  endfunction : thermo_of

  task automatic bad(input string msg);
    mismatches++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad

  task automatic check_outputs(input logic [15:0] exp);
    num_checks++;
    if (code !== exp || ladder !== exp[11:0] || segment !== thermo_of(exp)) bad("code or switch outputs");
  endtask : check_outputs

  task automatic check_flags(input logic p, input logic s, input logic l);
    num_checks++;
    if ({pending, short_f, long_f} !== {p, s, l}) bad("frame status");
  endtask : check_flags

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : settle

  task automatic finish_test;
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  initial begin
    #400000;
    bad("run did not end");
    finish_test;
  end

  initial begin
    clk_sys_in = 1'b0;
    reset_in = 1'b1;
    mismatches = 0;
    num_checks = 0;
    seed = 32'h0000_0025;
    repeat (5) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    settle(1);
    check_outputs(16'h0000);
    check_flags(1'b0, 1'b0, 1'b0);
    // Every upper nibble, then corner codes, then random words
    for (int i = 0; i < 24; i++) begin
      seed = xorshift(seed);
      word = (i < 16) ? {i[3:0], seed[11:0]} : (i < 20) ? corners[i-16] : seed[15:0];
      host.send({16'h0000, word}, 16, 1'b1);
      settle(10);
      check_outputs(word);
      check_flags(1'b0, 1'b0, 1'b0);
      held = word;
    end
    host.set_strobe(1'b1);
    word = ~held;
    host.send({16'h0000, word}, 16, 1'b1);
    settle(10);
    check_outputs(held);
    check_flags(1'b1, 1'b0, 1'b0);
    // Clock edges with select released must not disturb the preload
    host.send(seed, 16, 1'b0);
    settle(2);
    host.set_strobe(1'b0);
    settle(8);
    check_outputs(word);
    check_flags(1'b0, 1'b0, 1'b0);
    held = word;
    seed = xorshift(seed);
    host.send(seed, 12, 1'b1);
    settle(10);
    check_outputs(held);
    check_flags(1'b0, 1'b1, 1'b0);
    host.send(seed, 20, 1'b1);
    settle(10);
    check_outputs(seed[15:0]);
    check_flags(1'b0, 1'b0, 1'b1);
    reset_in = 1'b1;
    settle(3);
    reset_in = 1'b0;
    settle(1);
    check_outputs(16'h0000);
    check_flags(1'b0, 1'b0, 1'b0);
    finish_test;
  end
endmodule : sdl_top_tb

`default_nettype wire
